/* File: hw/dses_pkg.sv */
/*
 * Holds the shared constants of the DMA status and event summary block.
 * These are the register offsets, the field positions, the reset values and
 * the state and fault encodings.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
`default_nettype none

package dses_pkg;

    // Register byte offsets.
    localparam logic [7:0] DMA_STATUS_OFS = 8'h28;
    localparam logic [7:0] EVENT_MASK_OFS = 8'h38;

    // Reset values of the status and mask registers.
    localparam logic [31:0] DMA_STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] EVENT_MASK_RST = 32'h0000_0000;

    // Event flag positions in the status register.
    localparam int TX_DONE_BIT = 0;
    localparam int TX_HALT_BIT = 1;
    localparam int TX_DESC_BIT = 2;
    localparam int JABBER_BIT = 3;
    localparam int TX_UFLOW_BIT = 5;
    localparam int RX_DONE_BIT = 6;
    localparam int RX_DESC_BIT = 7;
    localparam int RX_HALT_BIT = 8;
    localparam int RX_WDOG_BIT = 9;
    localparam int GP_TIMER_BIT = 11;
    localparam int FATAL_BIT = 13;
    localparam int ABN_SUM_BIT = 15;
    localparam int NRM_SUM_BIT = 16;
    localparam int RX_STATE_LSB = 17;
    localparam int TX_STATE_LSB = 20;
    localparam int FAULT_TYPE_LSB = 23;

    // Latched event flags that software clears by writing one.
    localparam logic [13:0] EVENT_BITS = 14'h2BEF;
    // Event flags that feed each summary.
    localparam logic [13:0] NORMAL_SET = 14'h0045;
    localparam logic [13:0] ABNORMAL_SET = 14'h2BAA;
    // Bits of the mask register that software may write.
    localparam logic [31:0] MASK_BITS = 32'h0001_ABEF;

    // Transmit process states.
    localparam logic [2:0] TX_STOP = 3'h0;
    // Receive process states.
    localparam logic [2:0] RX_STOP = 3'h0;
    localparam logic [2:0] RX_SUSPENDED = 3'h4;

    // Bus fault type encodings.
    localparam logic [2:0] FAULT_PARITY = 3'h0;
    localparam logic [2:0] FAULT_MASTER = 3'h1;
    localparam logic [2:0] FAULT_TARGET = 3'h2;

    // AHB-Lite transfer type of a non-sequential access.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

`default_nettype wire

/* File: hw/dses_sticky_flags.sv */
/*
 * Holds a vector of sticky flags that hardware sets and software clears.
 * Assumes that set and clear pulses come from logic on the same clock.
 */
`default_nettype none

module dses_sticky_flags #(
    parameter int WIDTH = 14
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Per-bit set, per-bit clear and synchronous wipe.
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clear_in,
    input wire logic wipe_in,
    // Current flag values.
    output logic [WIDTH-1:0] flags_out
);

    logic [WIDTH-1:0] flags_q; // Latched flags.

    // A set in the same cycle as a clear wins, so no event is lost to a clear; a wipe in that cycle beats both.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_q <= '0;
        end else if (wipe_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clear_in) | set_in;
        end
    end

    assign flags_out = flags_q;

endmodule

`default_nettype wire

/* File: hw/dses_ahb_port.sv */
/*
 * Holds the AHB-Lite slave front end: it captures the address phase and
 * turns the data phase into a one-cycle write strobe.
 * Assumes one master, single word transfers and zero wait states.
 */
`default_nettype none

module dses_ahb_port (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // AHB-Lite slave signals.
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    // Decoded access towards the register file.
    output logic rd_take_out,
    output logic [7:0] rd_addr_out,
    output logic wr_stb_out,
    output logic [7:0] wr_addr_out
);

    logic wr_pend_q; // A write data phase follows.
    logic [7:0] wr_addr_q; // Address of that write.
    logic take; // Address phase accepted this cycle.

    // Only NONSEQ transfers are used; IDLE and BUSY are ignored.
    assign take = hsel_in && hready_in && (htrans_in == dses_pkg::HTRANS_NONSEQ);
    assign rd_take_out = take && !hwrite_in;
    assign rd_addr_out = haddr_in[7:0];

    // Remember a write address phase for its data phase.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite_in;
            if (take) begin
                wr_addr_q <= haddr_in[7:0];
            end
        end
    end

    assign wr_stb_out = wr_pend_q;
    assign wr_addr_out = wr_addr_q;

endmodule

`default_nettype wire

/* File: hw/dses_status_block.sv */
/*
 * Holds the DMA status and event summary block: process state fields,
 * latched event flags, summaries, fatal bus fault handling, an interrupt
 * mask and the AHB-Lite register access.
 * Assumes that the DMA engines, timers and bus master run on core_clk_in
 * and give one-cycle event pulses, so none of their signals is synchronised.
 */
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
// Summary of operation
// - Transmit state shown as read-only 3-bit field.
// - Receive state shown as read-only 3-bit field.
// - Normal summary from bits 0, 2, 6.
// - Abnormal summary from the eight abnormal flags.
// - Auxiliary summaries fold into both summary flags.
// - Events latch high until software writes one.
// - Bus faults set fatal flag, halting bus access.
// - General timer expiry sets its flag.
// - Receive watchdog expiry sets its flag.
// - Receive stop state entry sets its flag.
// - Missing receive descriptor flags and suspends reception.
// - Fault type field valid while fatal flag set.
`default_nettype none

module dses_status_block (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // AHB-Lite slave port.
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Process states from the DMA engines.
    input wire logic [2:0] transmit_state_in,
    input wire logic [2:0] receive_state_in,
    // Event pulses from the DMA engines and timers.
    input wire logic tx_done_in,
    input wire logic tx_desc_missing_in,
    input wire logic tx_jabber_in,
    input wire logic tx_underflow_in,
    input wire logic rx_done_in,
    input wire logic rx_descriptor_missing_in,
    input wire logic rx_watchdog_expired_in,
    input wire logic gp_timer_expired_in,
    // Bus fault pulses from the system bus master.
    input wire logic bus_parity_fault_in,
    input wire logic bus_master_abort_in,
    input wire logic bus_target_abort_in,
    // Receive resume causes.
    input wire logic rx_poll_demand_in,
    input wire logic rx_new_frame_in,
    // Summary bits of the auxiliary status register.
    input wire logic aux_normal_summary_in,
    input wire logic aux_abnormal_summary_in,
    // Software reset command.
    input wire logic soft_reset_cmd_in,
    // Control outputs.
    output logic bus_access_enable_out,
    output logic rx_suspend_out,
    output logic irq_out
);

    // Decoded bus access.
    logic rd_take; // Read address phase accepted.
    logic [7:0] rd_addr; // Read address.
    logic wr_stb; // Write data phase strobe.
    logic [7:0] wr_addr; // Write address.

    // Register state.
    logic [2:0] transmit_state_q; // Registered transmit state.
    logic [2:0] receive_state_q; // Registered receive state.
    logic [2:0] bus_fault_type_q; // Type of the first bus fault.
    logic bus_halt_q; // Bus access stopped after a fatal fault.
    logic rx_suspend_q; // Reception suspended for want of a descriptor.
    logic [31:0] event_mask_q; // Interrupt mask, status layout.
    logic [31:0] hrdata_q; // Read data for the data phase.
    logic irq_q; // Registered interrupt line.

    // Flag vectors.
    logic [13:0] event_set; // Events arriving this cycle.
    logic [13:0] event_clear; // Write-one-to-clear pulses.
    logic [13:0] event_flags; // Latched event flags.
    logic normal_event_summary; // Normal summary bit.
    logic abnormal_event_summary; // Abnormal summary bit.
    logic fatal_bus_fault; // Fatal bus fault flag.
    logic any_bus_fault; // Any fault pulse this cycle.
    logic tx_enters_stop; // Transmit process just stopped.
    logic rx_process_halted; // Receive process just stopped.
    logic [31:0] dma_status_reg; // Assembled status word.

    // Front end for the AHB-Lite bus.
    dses_ahb_port u_ahb_port (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hready_in(hready_in),
        .rd_take_out(rd_take),
        .rd_addr_out(rd_addr),
        .wr_stb_out(wr_stb),
        .wr_addr_out(wr_addr)
    );

    // Every access is answered at once and always OKAY; hsize is not decoded
    // because only whole-word transfers occur.
    // No access ever waits.
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // Register the process states so the read field and stop detection
    // see the same value.
    // Codes 100 and 101 pass through.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            transmit_state_q <= dses_pkg::TX_STOP;
            receive_state_q <= dses_pkg::RX_STOP;
        end else begin
            transmit_state_q <= transmit_state_in;
            receive_state_q <= receive_state_in;
        end
    end

    // Stop flags fire only on entry to the stop state, not while resting in it,
    // so clearing them while stopped keeps them clear.
    // A stop held in reset sets nothing.
    assign tx_enters_stop = (transmit_state_in == dses_pkg::TX_STOP) &&
                            (transmit_state_q != dses_pkg::TX_STOP);
    assign rx_process_halted = (receive_state_in == dses_pkg::RX_STOP) &&
                               (receive_state_q != dses_pkg::RX_STOP);

    // All three share one fatal flag.
    assign any_bus_fault = bus_parity_fault_in || bus_master_abort_in || bus_target_abort_in;

    // Gather the event pulses into their flag positions.
    // Bits 4, 10 and 12 stay empty.
    always_comb begin
        event_set = 14'h0000;
        event_set[dses_pkg::TX_DONE_BIT] = tx_done_in;
        event_set[dses_pkg::TX_HALT_BIT] = tx_enters_stop;
        event_set[dses_pkg::TX_DESC_BIT] = tx_desc_missing_in;
        event_set[dses_pkg::JABBER_BIT] = tx_jabber_in;
        event_set[dses_pkg::TX_UFLOW_BIT] = tx_underflow_in;
        event_set[dses_pkg::RX_DONE_BIT] = rx_done_in;
        event_set[dses_pkg::RX_DESC_BIT] = rx_descriptor_missing_in;
        event_set[dses_pkg::RX_HALT_BIT] = rx_process_halted;
        event_set[dses_pkg::RX_WDOG_BIT] = rx_watchdog_expired_in;
        event_set[dses_pkg::GP_TIMER_BIT] = gp_timer_expired_in;
        event_set[dses_pkg::FATAL_BIT] = any_bus_fault;
    end

    // Writing one clears a flag; zeros and reserved positions do nothing.
    // They drop at the end of the data phase.
    assign event_clear = (wr_stb && wr_addr == dses_pkg::DMA_STATUS_OFS) ?
                         (hwdata_in[13:0] & dses_pkg::EVENT_BITS) : 14'h0000;

    // The latched event flags themselves.
    // Soft reset wipes them all.
    dses_sticky_flags #(
        .WIDTH(14)
    ) u_event_flags (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(event_set),
        .clear_in(event_clear),
        .wipe_in(soft_reset_cmd_in),
        .flags_out(event_flags)
    );

    // It also qualifies the type.
    assign fatal_bus_fault = event_flags[dses_pkg::FATAL_BIT];

    // Summaries follow their flags, so they drop as soon as the last
    // contributing flag is cleared and stay while any remains.
    // Summary writes do nothing.
    assign normal_event_summary = |(event_flags & dses_pkg::NORMAL_SET) ||
                                  aux_normal_summary_in;
    assign abnormal_event_summary = |(event_flags & dses_pkg::ABNORMAL_SET) ||
                                    aux_abnormal_summary_in;

    // Capture the fault type when the fatal flag is first raised; a later
    // fault must not overwrite the cause software is about to read.
    // Reset gives the parity code.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_fault_type_q <= dses_pkg::FAULT_PARITY;
        end else if (soft_reset_cmd_in) begin
            bus_fault_type_q <= dses_pkg::FAULT_PARITY;
        end else if (any_bus_fault && !fatal_bus_fault) begin
            // Parity beats master abort.
            if (bus_parity_fault_in) begin
                bus_fault_type_q <= dses_pkg::FAULT_PARITY;
            end else if (bus_master_abort_in) begin
                bus_fault_type_q <= dses_pkg::FAULT_MASTER;
            end else begin
                bus_fault_type_q <= dses_pkg::FAULT_TARGET;
            end
        end
    end

    // Bus access stays disabled after a fatal fault even if the flag is
    // cleared; only a soft reset brings the bus master back.
    // A fault beats a soft reset.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_halt_q <= 1'b0;
        end else if (any_bus_fault) begin
            bus_halt_q <= 1'b1;
        end else if (soft_reset_cmd_in) begin
            bus_halt_q <= 1'b0;
        end
    end

    // High while DMA may use the bus.
    assign bus_access_enable_out = !bus_halt_q;

    // Receive suspension lasts until a poll demand, a new frame or a soft reset; a new
    // missing-descriptor event in the same cycle keeps it suspended.
    // Clearing bit 7 does not lift it.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_suspend_q <= 1'b0;
        end else if (rx_descriptor_missing_in) begin
            rx_suspend_q <= 1'b1;
        end else if (soft_reset_cmd_in || rx_poll_demand_in || rx_new_frame_in) begin
            rx_suspend_q <= 1'b0;
        end
    end

    // Tells the receiver to wait.
    assign rx_suspend_out = rx_suspend_q;

    // Assemble the status word; unassigned positions read as zero.
    // Rebuilt every cycle.
    always_comb begin
        dma_status_reg = 32'h0000_0000;
        dma_status_reg[13:0] = event_flags & dses_pkg::EVENT_BITS;
        dma_status_reg[dses_pkg::ABN_SUM_BIT] = abnormal_event_summary;
        dma_status_reg[dses_pkg::NRM_SUM_BIT] = normal_event_summary;
        dma_status_reg[dses_pkg::RX_STATE_LSB +: 3] = receive_state_q;
        dma_status_reg[dses_pkg::TX_STATE_LSB +: 3] = transmit_state_q;
        // The type field shows zero unless the fatal flag makes it valid.
        dma_status_reg[dses_pkg::FAULT_TYPE_LSB +: 3] =
            fatal_bus_fault ? bus_fault_type_q : 3'h0;
    end

    // Mask register; a one lets the matching status bit raise the interrupt.
    // Other bits stay zero.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            event_mask_q <= dses_pkg::EVENT_MASK_RST;
        end else if (wr_stb && wr_addr == dses_pkg::EVENT_MASK_OFS) begin
            event_mask_q <= hwdata_in & dses_pkg::MASK_BITS;
        end
    end

    // Read data is sampled at the address phase, so the answer needs no
    // wait state; unmapped addresses read zero.
    // Only the low byte is decoded.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            if (rd_addr == dses_pkg::DMA_STATUS_OFS) begin
                hrdata_q <= dma_status_reg;
            end else if (rd_addr == dses_pkg::EVENT_MASK_OFS) begin
                hrdata_q <= event_mask_q;
            end else begin
                hrdata_q <= 32'h0000_0000;
            end
        end
    end

    // Stands until the next read.
    assign hrdata_out = hrdata_q;

    // The interrupt is registered to keep glitches off the line; it follows
    // the masked status one cycle late.
    // Summaries may be unmasked too.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(dma_status_reg & event_mask_q & dses_pkg::MASK_BITS);
        end
    end

    // A level, high while unmasked.
    assign irq_out = irq_q;

endmodule

`default_nettype wire

/* File: dv/dses_status_props.sv */
/*
 * Concurrent checks on the ports of the DMA status and event summary block.
 * Assumes one core clock, the active-low reset and whole-word bus reads.
 */
`default_nettype none

module dses_status_props (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Bus address phase and read data.
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    // Process state, faults and summaries.
    input wire logic [2:0] transmit_state_in,
    input wire logic bus_parity_fault_in,
    input wire logic bus_master_abort_in,
    input wire logic bus_target_abort_in,
    input wire logic rx_descriptor_missing_in,
    input wire logic aux_normal_summary_in,
    input wire logic aux_abnormal_summary_in,
    input wire logic soft_reset_cmd_in,
    // Control outputs.
    input wire logic bus_access_enable_out,
    input wire logic rx_suspend_out
);
    default clocking dflt @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // A status read taken at this edge shows its data in the next cycle.
    wire logic rd_st = hsel_in && hready_in && htrans_in == dses_pkg::HTRANS_NONSEQ && !hwrite_in
        && haddr_in[7:0] == dses_pkg::DMA_STATUS_OFS;
    // Any of the three bus faults.
    wire logic fault = bus_parity_fault_in || bus_master_abort_in || bus_target_abort_in;

    // The field may be registered, so only a steady input is compared.
    AST_TX_STATE: assert property (
        rd_st && $stable(transmit_state_in) |=> hrdata_out[22:20] == $past(transmit_state_in))
        else $error("transmit state field differs from its input");
    AST_NORMAL_SUM: assert property (
        rd_st |=> hrdata_out[16] == (hrdata_out[0] | hrdata_out[2] | hrdata_out[6] | $past(aux_normal_summary_in)))
        else $error("normal summary does not match its flags");
    AST_ABNORMAL_SUM: assert property (
        rd_st |=> hrdata_out[15] == ((|(hrdata_out[13:0] & 14'h2BAA)) | $past(aux_abnormal_summary_in)))
        else $error("abnormal summary does not match its flags");
    AST_RESERVED_ZERO: assert property (
        rd_st |=> hrdata_out[31:26] == 6'h00 && {hrdata_out[14], hrdata_out[12], hrdata_out[10], hrdata_out[4]} == 4'h0)
        else $error("reserved status bit reads nonzero");
    AST_FAULT_TYPE: assert property (
        rd_st |=> (hrdata_out[13] || hrdata_out[25:23] == 3'h0) && hrdata_out[25:23] <= 3'h2)
        else $error("fault type field invalid");
    AST_BUS_HALT: assert property (
        fault |=> !bus_access_enable_out)
        else $error("bus access still enabled after fault");
    AST_HALT_HOLD: assert property (
        !bus_access_enable_out && !soft_reset_cmd_in |=> !bus_access_enable_out)
        else $error("bus access enabled without soft reset");
    AST_SOFT_RESET: assert property (
        soft_reset_cmd_in && !fault |=> bus_access_enable_out)
        else $error("soft reset did not restore bus access");
    AST_RX_SUSPEND: assert property (
        rx_descriptor_missing_in |=> rx_suspend_out)
        else $error("missing descriptor did not suspend reception");
endmodule

bind dses_status_block dses_status_props u_props (
    .core_clk_in,
    .reset_n_in,
    .hsel_in,
    .haddr_in,
    .htrans_in,
    .hwrite_in,
    .hready_in,
    .hrdata_out,
    .transmit_state_in,
    .bus_parity_fault_in,
    .bus_master_abort_in,
    .bus_target_abort_in,
    .rx_descriptor_missing_in,
    .aux_normal_summary_in,
    .aux_abnormal_summary_in,
    .soft_reset_cmd_in,
    .bus_access_enable_out,
    .rx_suspend_out
);

`default_nettype wire

/* File: dv/tb_top.sv */
/*
 * Self-checking bench of the DMA status and event summary block.
 * Assumes the package, the design and the checker are compiled first.
 */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and bus.
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic [31:0] hrdata;
    wire logic hready;
    wire logic hresp;
    // States, events by flag position, faults, resume and soft reset.
    logic [2:0] ts = 3'h0;
    logic [2:0] rs = 3'h0;
    logic [11:0] ev = 12'h000;
    logic [2:0] flt = 3'h0;
    logic [2:0] ctl = 3'h0;
    logic auxn = 1'b0;
    logic auxa = 1'b0;
    wire logic bus_en;
    wire logic susp;
    wire logic irq;
    // Reference model and counters.
    logic [13:0] m_flags = 14'h0000;
    logic [2:0] m_type = 3'h0;
    logic [31:0] m_mask = 32'h0000_0000;
    logic m_susp = 1'b0;
    logic m_halt = 1'b0;
    logic [31:0] rd;
    int n_errors = 0;
    int n_checks = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    dses_status_block u_dut (
        .core_clk_in(clk),
        .reset_n_in(rst_n),
        .hsel_in(hsel),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(3'h2),
        .hready_in(hready),
        .hwdata_in(hwdata),
        .hrdata_out(hrdata),
        .hreadyout_out(hready),
        .hresp_out(hresp),
        .transmit_state_in(ts),
        .receive_state_in(rs),
        .tx_done_in(ev[0]),
        .tx_desc_missing_in(ev[2]),
        .tx_jabber_in(ev[3]),
        .tx_underflow_in(ev[5]),
        .rx_done_in(ev[6]),
        .rx_descriptor_missing_in(ev[7]),
        .rx_watchdog_expired_in(ev[9]),
        .gp_timer_expired_in(ev[11]),
        .bus_parity_fault_in(flt[0]),
        .bus_master_abort_in(flt[1]),
        .bus_target_abort_in(flt[2]),
        .rx_poll_demand_in(ctl[0]),
        .rx_new_frame_in(ctl[1]),
        .aux_normal_summary_in(auxn),
        .aux_abnormal_summary_in(auxa),
        .soft_reset_cmd_in(ctl[2]),
        .bus_access_enable_out(bus_en),
        .rx_suspend_out(susp),
        .irq_out(irq)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compares one value with its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits for hready at a rising edge; a stuck bus ends the run.
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 16);
        if (hready !== 1'b1) begin
            n_errors++;
            results();
        end
    endtask

    // One single-word transfer; read data lands in rd.
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= dses_pkg::HTRANS_NONSEQ;
        haddr <= {24'h00_0000, adr};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    // Expected status word, built from the flag positions.
    function automatic logic [31:0] exp_st();
        logic [31:0] v;
        v = 32'h0000_0000;
        v[13:0] = m_flags;
        v[15] = (|(m_flags & 14'h2BAA)) | auxa;
        v[16] = m_flags[0] | m_flags[2] | m_flags[6] | auxn;
        v[22:20] = ts;
        v[19:17] = rs;
        if (m_flags[13]) begin
            v[25:23] = m_type;
        end
        return v;
    endfunction

    // One-cycle pulse of events, faults and controls with new states; updates the model.
    task automatic pulse(input logic [11:0] e, input logic [2:0] f, input logic [2:0] c,
                         input logic [2:0] nts, input logic [2:0] nrs);
        @(posedge clk);
        if (c != 3'h0) m_susp = 1'b0;
        if (c[2]) begin
            m_flags = 14'h0000;
            m_halt = 1'b0;
        end
        if (ts != 3'h0 && nts == 3'h0) m_flags[1] = 1'b1;
        if (rs != 3'h0 && nrs == 3'h0) m_flags[8] = 1'b1;
        m_flags = m_flags | {2'h0, e};
        if (e[7]) m_susp = 1'b1;
        if (f != 3'h0) begin
            if (!m_flags[13]) m_type = f[0] ? 3'h0 : (f[1] ? 3'h1 : 3'h2);
            m_flags[13] = 1'b1;
            m_halt = 1'b1;
        end
        ts <= nts;
        rs <= nrs;
        ev <= e;
        flt <= f;
        ctl <= c;
        @(posedge clk);
        ev <= 12'h000;
        flt <= 3'h0;
        ctl <= 3'h0;
    endtask

    // Reads the status and compares it and the control outputs with the model.
    task automatic verify();
        bus(1'b0, dses_pkg::DMA_STATUS_OFS, 32'h0000_0000);
        check(rd, exp_st());
        check({29'h0, bus_en, susp, irq}, {29'h0, ~m_halt, m_susp, |(exp_st() & m_mask)});
    endtask

    initial begin
        logic [2:0] f;
        logic [31:0] wd;
        void'($urandom(32'h9769));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        verify();
        bus(1'b1, 8'h30, 32'hFFFF_FFFF);
        bus(1'b0, 8'h30, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0, hresp}, 32'h0000_0000);
        // Random events, states, summaries, clears and mask writes.
        for (int i = 0; i < 60; i++) begin
            auxn <= ($urandom_range(3, 0) == 0);
            auxa <= ($urandom_range(3, 0) == 0);
            pulse(12'($urandom & $urandom) & 12'hAED, 3'h0, {1'b0, 2'($urandom & $urandom)},
                  ($urandom_range(3, 0) == 0) ? 3'h0 : 3'($urandom),
                  ($urandom_range(3, 0) == 0) ? 3'h0 : 3'($urandom));
            verify();
            if ($urandom_range(2, 0) == 0) begin
                wd = $urandom;
                bus(1'b1, dses_pkg::DMA_STATUS_OFS, wd);
                m_flags = m_flags & ~wd[13:0];
                verify();
            end
            if ($urandom_range(3, 0) == 0) begin
                wd = $urandom;
                bus(1'b1, dses_pkg::EVENT_MASK_OFS, wd);
                m_mask = wd & dses_pkg::MASK_BITS;
                bus(1'b0, dses_pkg::EVENT_MASK_OFS, 32'h0000_0000);
                check(rd, m_mask);
            end
        end
        // Each fault type with lower-priority faults alongside, a later fault, then a clear.
        for (int t = 0; t < 3; t++) begin
            pulse(12'h000, 3'h0, 3'h4, ts, rs);
            verify();
            f = 3'(1 << t) | (3'($urandom) & (3'h7 << (t + 1)));
            pulse(12'h000, f, 3'h0, ts, rs);
            verify();
            pulse(12'h000, 3'(1 << ((t + 1) % 3)), 3'h0, ts, rs);
            verify();
            bus(1'b1, dses_pkg::DMA_STATUS_OFS, 32'h0000_2000);
            m_flags[13] = 1'b0;
            verify();
        end
        pulse(12'h000, 3'h0, 3'h4, ts, rs);
        verify();
        results();
    end
endmodule

`default_nettype wire
